// file: hw/cgs_pkg.sv
// constants for the clock generator selector: register map, fields, resets
// assumes a single core clock and byte-wide registers on 32-bit words
package cgs_pkg;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CORE_CLK_HZ = 50_000_000;
  localparam int unsigned NOM_FREQ_HZ = 38_400; // center-of-range unit frequency
  localparam int unsigned SWITCH_STAGES = 3; // edges of each source per hand-over: old side shifts out, then new side shifts in
  localparam int unsigned BUS_DIV = 4; // bus clock versus selected source

  // ---------------------------------------------------------------------------
  // register indices, byte address is four times the index
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W = 10;
  localparam logic [7:0] IDX_CTRL = 8'h1a;
  localparam logic [7:0] IDX_BWC = 8'h1b;
  localparam logic [7:0] IDX_MULH = 8'h1c;
  localparam logic [7:0] IDX_MULL = 8'h1d;
  localparam logic [7:0] IDX_VRS = 8'h1e;
  localparam logic [7:0] IDX_RDS = 8'h1f;
  localparam logic [7:0] IDX_STAT = 8'h20;
  localparam logic [7:0] IDX_CENTER = 8'h21;

  // ---------------------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int unsigned CTRL_IE = 7;
  localparam int unsigned CTRL_ON = 5;
  localparam int unsigned CTRL_SEL = 4;
  localparam int unsigned CTRL_PRE_LSB = 2;
  localparam int unsigned CTRL_EXP_LSB = 0;
  localparam int unsigned BWC_AUTO = 7;
  localparam int unsigned BWC_ACQ = 5;
  localparam logic [7:0] CTRL_RST = 8'h2f;
  localparam logic [7:0] BWC_RST = 8'h00;
  localparam logic [11:0] MUL_RST = 12'h000;
  localparam logic [7:0] VRS_RST = 8'h40;
  localparam logic [3:0] RDS_RST = 4'h1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: hw/cgs_edge_if.sv
// edge pulses of the sampled crystal and vco clocks, core clock domain
// assumes both pulses are one core cycle wide
`timescale 1ns/1ns
interface cgs_edge_if;
  logic x_rise;
  logic v_rise;
  modport src (output x_rise, output v_rise);
  modport dst (input x_rise, input v_rise);
endinterface

// file: hw/cgs_clk_div.sv
// modulo divider of an edge pulse train
// assumes modulus is never zero; callers map zero beforehand
`timescale 1ns/1ns
module cgs_clk_div
  import cgs_pkg::*;
#(
  parameter int unsigned W = 12
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_pulse_i,
  input wire logic [W-1:0] modulus_i,
  output logic out_pulse_o
);

  logic [W-1:0] cnt_q, cnt_d;
  logic out_d;

  // ---------------------------------------------------------------------------
  // count input pulses, emit one pulse per modulus
  // ---------------------------------------------------------------------------
  always_comb
  begin
    cnt_d = cnt_q;
    out_d = 1'b0;
    if (in_pulse_i)
    begin
      if (cnt_q >= modulus_i - W'(1))
      begin
        cnt_d = '0;
        out_d = 1'b1;
      end
      else
        cnt_d = cnt_q + W'(1);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q <= '0;
      out_pulse_o <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      out_pulse_o <= out_d;
    end
  end

endmodule // cgs_clk_div

// file: hw/cgs_clk_switch.sv
// glitch-free hand-over between crystal and vco, then divide by two and four
// assumes edge pulses from the edge interface and a core-domain select
`timescale 1ns/1ns
module cgs_clk_switch
  import cgs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  cgs_edge_if.dst edge_if,
  input wire logic sel_vco_i,
  output logic base_clk_o,
  output logic bus_clk_o,
  output logic active_vco_o,
  output logic in_transit_o
);

  logic [SWITCH_STAGES-1:0] x_sh_q, x_sh_d, v_sh_q, v_sh_d;
  logic base_d, bus_d;
  logic x_en, v_en, tick;

  assign x_en = x_sh_q[SWITCH_STAGES-1];
  assign v_en = v_sh_q[SWITCH_STAGES-1];
  assign tick = (x_en & edge_if.x_rise) | (v_en & edge_if.v_rise);
  assign active_vco_o = v_en;
  assign in_transit_o = !(x_en && !sel_vco_i) && !(v_en && sel_vco_i);

  // ---------------------------------------------------------------------------
  // each source's enable is shifted by that source's own edges
  // ---------------------------------------------------------------------------
  always_comb
  begin
    x_sh_d = x_sh_q;
    v_sh_d = v_sh_q;
    base_d = base_clk_o;
    bus_d = bus_clk_o;
    if (edge_if.x_rise)
      x_sh_d = {x_sh_q[SWITCH_STAGES-2:0], !sel_vco_i && !(|v_sh_q)};
    if (edge_if.v_rise)
      v_sh_d = {v_sh_q[SWITCH_STAGES-2:0], sel_vco_i && !(|x_sh_q)};
    if (tick)
    begin
      base_d = !base_clk_o;
      if (!base_clk_o)
        bus_d = !bus_clk_o;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      x_sh_q <= '1;
      v_sh_q <= '0;
      base_clk_o <= 1'b0;
      bus_clk_o <= 1'b0;
    end
    else
    begin
      x_sh_q <= x_sh_d;
      v_sh_q <= v_sh_d;
      base_clk_o <= base_d;
      bus_clk_o <= bus_d;
    end
  end

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  property p_one_source;
    @(posedge clk_i) disable iff (!rst_n_i) !(x_en && v_en);
  endproperty
  a_one_source: assert property (p_one_source) else $error("both sources enabled");

  property p_stasis;
    @(posedge clk_i) disable iff (!rst_n_i) (!x_en && !v_en) |=> $stable(base_clk_o);
  endproperty
  a_stasis: assert property (p_stasis) else $error("base clock moved in transit");

endmodule // cgs_clk_switch

// file: hw/cgs_top.sv
// clock generator selector: divider programming, base clock selection
// assumes AXI4-Lite on the core clock; oscillator and vco arrive as pins
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module cgs_top
  import cgs_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic OSC_AMP_IN_I,
  input wire logic VCO_CLOCK_I,
  input wire logic OSC_ENABLE_IN_I,
  output logic CRYSTAL_CLOCK_O,
  output logic BUFFERED_CRYSTAL_OUT_O,
  output logic BASE_CLOCK_OUT_O,
  output logic BUS_CLOCK_O,
  output logic PLL_POWER_ON_O,
  output logic REF_DIV_CLOCK_O,
  output logic VCO_FB_CLOCK_O,
  output logic [1:0] PRESCALE_EXP_O,
  output logic [11:0] FB_MULT_O,
  output logic [3:0] REF_DIV_O,
  output logic [1:0] RANGE_EXP_O,
  output logic [7:0] LINEAR_FACTOR_O
);

  // maps a programmed zero onto one
  function automatic logic [11:0] zero_as_one(input logic [11:0] v);
    zero_as_one = (v == 12'h000) ? 12'h001 : v;
  endfunction

  // register index from a byte address
  function automatic logic [7:0] reg_idx(input logic [ADDR_W-1:0] a);
    reg_idx = a[ADDR_W-1:2];
  endfunction

  // ---------------------------------------------------------------------------
  // pin sampling: two flops, then a third for edge detection
  // ---------------------------------------------------------------------------
  logic [2:0] x_s_q, v_s_q;
  logic [1:0] en_s_q;
  logic pll_run;
  cgs_edge_if edges ();

  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      x_s_q <= 3'h0;
      v_s_q <= 3'h0;
      en_s_q <= 2'h0;
    end
    else
    begin
      x_s_q <= {x_s_q[1:0], OSC_AMP_IN_I};
      v_s_q <= {v_s_q[1:0], VCO_CLOCK_I};
      en_s_q <= {en_s_q[0], OSC_ENABLE_IN_I};
    end
  end

  assign edges.x_rise = x_s_q[1] & ~x_s_q[2] & en_s_q[1];
  assign edges.v_rise = v_s_q[1] & ~v_s_q[2]; // ungated so the switch can always flush its vco side

  // crystal gated by the enable pin, and buffered out ungated
  assign CRYSTAL_CLOCK_O = OSC_AMP_IN_I & OSC_ENABLE_IN_I;
  assign BUFFERED_CRYSTAL_OUT_O = OSC_AMP_IN_I;

  // ---------------------------------------------------------------------------
  // bus write and read channels
  // ---------------------------------------------------------------------------
  logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d, bvalid_d, rvalid_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [7:0] wdata_q, wdata_d, rdata_d;
  logic wlane_q, wlane_d;
  logic [1:0] bresp_d, rresp_d;
  logic wr_go, rd_go, wr_hit, rd_hit;
  logic [7:0] wr_idx, rd_val;

  assign S_AXI_AWREADY_O = !aw_hold_q && !S_AXI_BVALID_O;
  assign S_AXI_WREADY_O = !w_hold_q && !S_AXI_BVALID_O;
  assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;
  assign wr_go = aw_hold_q && w_hold_q && !S_AXI_BVALID_O;
  assign rd_go = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  assign wr_idx = reg_idx(awaddr_q);
  assign wr_hit = wr_idx >= IDX_CTRL && wr_idx <= IDX_CENTER;
  assign rd_hit = reg_idx(S_AXI_ARADDR_I) >= IDX_CTRL && reg_idx(S_AXI_ARADDR_I) <= IDX_CENTER;

  // capture address and data in either order, answer when both are held
  always_comb
  begin
    aw_hold_d = aw_hold_q;
    w_hold_d = w_hold_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wlane_d = wlane_q;
    bvalid_d = S_AXI_BVALID_O;
    bresp_d = S_AXI_BRESP_O;
    rvalid_d = S_AXI_RVALID_O;
    rdata_d = S_AXI_RDATA_O[7:0];
    rresp_d = S_AXI_RRESP_O;
    if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
    begin
      aw_hold_d = 1'b1;
      awaddr_d = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && S_AXI_WREADY_O)
    begin
      w_hold_d = 1'b1;
      wdata_d = S_AXI_WDATA_I[7:0];
      wlane_d = S_AXI_WSTRB_I[0];
    end
    if (wr_go)
    begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (S_AXI_BVALID_O && S_AXI_BREADY_I)
      bvalid_d = 1'b0;
    if (rd_go)
    begin
      rvalid_d = 1'b1;
      rdata_d = rd_hit ? rd_val : 8'h00;
      rresp_d = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (S_AXI_RVALID_O && S_AXI_RREADY_I)
      rvalid_d = 1'b0;
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 8'h00;
      wlane_q <= 1'b0;
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= RESP_OKAY;
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O <= 32'h0000_0000;
      S_AXI_RRESP_O <= RESP_OKAY;
    end
    else
    begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wlane_q <= wlane_d;
      S_AXI_BVALID_O <= bvalid_d;
      S_AXI_BRESP_O <= bresp_d;
      S_AXI_RVALID_O <= rvalid_d;
      S_AXI_RDATA_O <= {24'h000000, rdata_d};
      S_AXI_RRESP_O <= rresp_d;
    end
  end

  // ---------------------------------------------------------------------------
  // programming registers with the on/select interlocks
  // ---------------------------------------------------------------------------
  logic ie_q, ie_d, on_q, on_d, sel_q, sel_d, auto_q, auto_d, acq_q, acq_d;
  logic [1:0] pre_q, pre_d, exp_q, exp_d;
  logic [11:0] mul_q, mul_d;
  logic [7:0] vrs_q, vrs_d;
  logic [3:0] rds_q, rds_d;
  logic wr_en;
  logic active_vco, in_transit;

  assign wr_en = wr_go && wr_hit && wlane_q;

  always_comb
  begin
    ie_d = ie_q;
    on_d = on_q;
    sel_d = sel_q;
    pre_d = pre_q;
    exp_d = exp_q;
    auto_d = auto_q;
    acq_d = acq_q;
    mul_d = mul_q;
    vrs_d = vrs_q;
    rds_d = rds_q;
    if (wr_en)
    begin
      unique case (wr_idx)
        IDX_CTRL:
        begin
          ie_d = wdata_q[CTRL_IE];
          on_d = wdata_q[CTRL_ON] | sel_q | (wdata_q[CTRL_SEL] & on_q);
          sel_d = wdata_q[CTRL_SEL] & on_q;
          if (!on_q)
          begin
            pre_d = wdata_q[CTRL_PRE_LSB +: 2];
            exp_d = wdata_q[CTRL_EXP_LSB +: 2];
          end
        end
        IDX_BWC:
        begin
          auto_d = wdata_q[BWC_AUTO];
          if (!auto_q)
            acq_d = wdata_q[BWC_ACQ];
        end
        IDX_MULH: mul_d[11:8] = wdata_q[3:0];
        IDX_MULL: mul_d[7:0] = wdata_q;
        IDX_VRS: vrs_d = wdata_q;
        IDX_RDS: rds_d = wdata_q[3:0];
        default: ;
      endcase
    end
    if (!auto_d)
      ie_d = 1'b0;
    if (vrs_d == 8'h00)
      sel_d = 1'b0;
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      ie_q <= CTRL_RST[CTRL_IE];
      on_q <= CTRL_RST[CTRL_ON];
      sel_q <= CTRL_RST[CTRL_SEL];
      pre_q <= CTRL_RST[CTRL_PRE_LSB +: 2];
      exp_q <= CTRL_RST[CTRL_EXP_LSB +: 2];
      auto_q <= BWC_RST[BWC_AUTO];
      acq_q <= BWC_RST[BWC_ACQ];
      mul_q <= MUL_RST;
      vrs_q <= VRS_RST;
      rds_q <= RDS_RST;
    end
    else
    begin
      ie_q <= ie_d;
      on_q <= on_d;
      sel_q <= sel_d;
      pre_q <= pre_d;
      exp_q <= exp_d;
      auto_q <= auto_d;
      acq_q <= acq_d;
      mul_q <= mul_d;
      vrs_q <= vrs_d;
      rds_q <= rds_d;
    end
  end

  // read values; lock and its flag are not modelled and read as zero
  always_comb
  begin
    unique case (reg_idx(S_AXI_ARADDR_I))
      IDX_CTRL: rd_val = {ie_q, 1'b0, on_q, sel_q, pre_q, exp_q};
      IDX_BWC: rd_val = {auto_q, 1'b0, acq_q, 5'h00};
      IDX_MULH: rd_val = {4'h0, mul_q[11:8]};
      IDX_MULL: rd_val = mul_q[7:0];
      IDX_VRS: rd_val = vrs_q;
      IDX_RDS: rd_val = {4'h0, rds_q};
      IDX_STAT: rd_val = {4'h0, in_transit, active_vco, pll_run, en_s_q[1]};
      IDX_CENTER: rd_val = 8'(vrs_q << exp_q);
      default: rd_val = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------------------
  // effective divider values and pll enable
  // ---------------------------------------------------------------------------
  assign pll_run = on_q && (vrs_q != 8'h00) && en_s_q[1];
  assign PLL_POWER_ON_O = pll_run;
  assign PRESCALE_EXP_O = pre_q;
  assign RANGE_EXP_O = exp_q;
  assign LINEAR_FACTOR_O = vrs_q;
  assign FB_MULT_O = zero_as_one(mul_q);
  assign REF_DIV_O = 4'(zero_as_one({8'h00, rds_q}));

  // ---------------------------------------------------------------------------
  // reference and feedback dividers, then the base clock switch
  // ---------------------------------------------------------------------------
  logic pre_pulse;

  cgs_clk_div #(.W(4)) u_ref_div (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RST_N_I),
    .in_pulse_i(edges.x_rise),
    .modulus_i(REF_DIV_O),
    .out_pulse_o(REF_DIV_CLOCK_O)
  );

  cgs_clk_div #(.W(4)) u_pre_div (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RST_N_I),
    .in_pulse_i(edges.v_rise & pll_run),
    .modulus_i(4'(4'h1 << pre_q)),
    .out_pulse_o(pre_pulse)
  );

  cgs_clk_div #(.W(12)) u_fb_div (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RST_N_I),
    .in_pulse_i(pre_pulse),
    .modulus_i(FB_MULT_O),
    .out_pulse_o(VCO_FB_CLOCK_O)
  );

  cgs_clk_switch u_switch (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RST_N_I),
    .edge_if(edges.dst),
    .sel_vco_i(sel_q),
    .base_clk_o(BASE_CLOCK_OUT_O),
    .bus_clk_o(BUS_CLOCK_O),
    .active_vco_o(active_vco),
    .in_transit_o(in_transit)
  );

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);

  property p_sel_needs_on;
    sel_q |-> on_q;
  endproperty
  a_sel_needs_on: assert property (p_sel_needs_on) else $error("vco selected with pll off");

  property p_set_refused;
    (wr_en && wr_idx == IDX_CTRL && wdata_q[CTRL_SEL] && !on_q) |=> !sel_q;
  endproperty
  a_set_refused: assert property (p_set_refused) else $error("select taken while pll off");

  property p_off_refused;
    (wr_en && wr_idx == IDX_CTRL && !wdata_q[CTRL_ON] && sel_q) |=> on_q;
  endproperty
  a_off_refused: assert property (p_off_refused) else $error("pll cleared while vco selected");

  property p_two_writes;
    $rose(sel_q) |-> $past(on_q);
  endproperty
  a_two_writes: assert property (p_two_writes) else $error("on and select in one write");

  property p_zero_linear;
    (vrs_q == 8'h00) |-> (!sel_q && !PLL_POWER_ON_O);
  endproperty
  a_zero_linear: assert property (p_zero_linear) else $error("zero linear factor not honoured");

  property p_zero_mult;
    (mul_q == 12'h000) |-> (FB_MULT_O == 12'h001 && FB_MULT_O != mul_q);
  endproperty
  a_zero_mult: assert property (p_zero_mult) else $error("zero multiplier not read as one");

  property p_pre_locked;
    (wr_en && wr_idx == IDX_CTRL && on_q) |=> $stable(pre_q) && $stable(exp_q);
  endproperty
  a_pre_locked: assert property (p_pre_locked) else $error("prescale written while pll on");

  property p_mult_split;
    (wr_en && wr_idx == IDX_MULH) |=> (mul_q[11:8] == $past(wdata_q[3:0])) && $stable(mul_q[7:0]);
  endproperty
  a_mult_split: assert property (p_mult_split) else $error("high multiplier write wrong");

  property p_write_answer;
    wr_go |=> S_AXI_BVALID_O;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write not answered");

endmodule // cgs_top

// file: dv/cgs_sim_model.sv
// integration-side model: crystal pin, vco clock and oscillator enable
// assumes a 20 ns core clock; periods given in core cycles
`timescale 1ns/1ns
module cgs_sim_model
#(
  parameter int XP = 10,
  parameter int VP = 6
)
(
  input wire logic en_req_i,
  output logic osc_o,
  output logic vco_o,
  output logic osc_en_o
);
  // --------------------------------------------------------------------------
  // free-running sources, edges kept off the core rising edge
  // --------------------------------------------------------------------------
  initial
  begin
    osc_o = 1'b0;
    vco_o = 1'b0;
  end
  always #(XP*10) osc_o = ~osc_o;
  always #(VP*10) vco_o = ~vco_o;
  // enable level driven on request of the bench
  assign osc_en_o = en_req_i;
endmodule // cgs_sim_model

// file: dv/test_cgs_top.sv
// self-checking bench of the clock generator selector
// assumes the integration-side model and AXI4-Lite register access
`timescale 1ns/1ns
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, (a), (e)); end end
module test_cgs_top
  import cgs_pkg::*;
;
  localparam int XP = 10;
  localparam int VP = 6;
  localparam logic [9:0] A_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [9:0] A_MULH = {IDX_MULH, 2'b00};
  localparam logic [9:0] A_MULL = {IDX_MULL, 2'b00};
  localparam logic [9:0] A_VRS = {IDX_VRS, 2'b00};
  localparam logic [9:0] A_RDS = {IDX_RDS, 2'b00};
  localparam logic [9:0] A_CTR = {IDX_CENTER, 2'b00};
  logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0, en_req = 1'b1;
  logic [9:0] awa = '0, ara = '0;
  logic [31:0] wd = '0, rdv;
  logic [3:0] strb = 4'h1;
  logic [1:0] resp;
  logic awr, wr_o, bv, arr, rv, osc, vco, oen, xc, bxc, base, busc, pon, refc, fbc;
  logic [1:0] bresp, rresp, pre, rexp;
  logic [31:0] rdata;
  logic [11:0] fbm;
  logic [3:0] rdiv;
  logic [7:0] lin;
  logic [3:0] mon;
  int n_fail = 0, n_tests = 0, per;
  assign mon = {fbc, refc, busc, base};
  always #10 clk = ~clk;
  cgs_sim_model #(.XP(XP), .VP(VP)) SIM (.en_req_i(en_req), .osc_o(osc), .vco_o(vco), .osc_en_o(oen));
  cgs_top DUT (.CORE_CLK_I(clk), .RST_N_I(rst_n), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
    .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(strb), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wr_o), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bre),
    .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rre), .OSC_AMP_IN_I(osc),
    .VCO_CLOCK_I(vco), .OSC_ENABLE_IN_I(oen), .CRYSTAL_CLOCK_O(xc), .BUFFERED_CRYSTAL_OUT_O(bxc),
    .BASE_CLOCK_OUT_O(base), .BUS_CLOCK_O(busc), .PLL_POWER_ON_O(pon), .REF_DIV_CLOCK_O(refc),
    .VCO_FB_CLOCK_O(fbc), .PRESCALE_EXP_O(pre), .FB_MULT_O(fbm), .REF_DIV_O(rdiv),
    .RANGE_EXP_O(rexp), .LINEAR_FACTOR_O(lin));
  // --------------------------------------------------------------------------
  // bus cycles
  // --------------------------------------------------------------------------
  // write one byte, hold each channel until taken, then take the response
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    bit ta, tw;
    ta = 0; tw = 0;
    awa <= a; wd <= {24'h0, d}; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
    do
    begin
      @(posedge clk);
      if (!ta && awr === 1'b1) begin ta = 1; awv <= 1'b0; end
      if (!tw && wr_o === 1'b1) begin tw = 1; wv <= 1'b0; end
    end while (!(ta && tw && bv === 1'b1));
    resp = bresp;
  endtask
  // read one word, response taken at the edge with rvalid
  task automatic rd(input logic [9:0] a);
    bit ta;
    ta = 0;
    ara <= a; arv <= 1'b1; rre <= 1'b1;
    do
    begin
      @(posedge clk);
      if (!ta && arr === 1'b1) begin ta = 1; arv <= 1'b0; end
    end while (!(ta && rv === 1'b1));
    rdv = rdata;
    resp = rresp;
  endtask
  // core cycles between two rising edges of a monitored clock
  task automatic meas(input int k);
    int c, s;
    c = 0;
    while (mon[k] !== 1'b1 && c < 900) begin @(posedge clk); #1; c++; end
    while (mon[k] !== 1'b0 && c < 900) begin @(posedge clk); #1; c++; end
    while (mon[k] !== 1'b1 && c < 900) begin @(posedge clk); #1; c++; end
    s = c;
    while (mon[k] !== 1'b0 && c < 900) begin @(posedge clk); #1; c++; end
    while (mon[k] !== 1'b1 && c < 900) begin @(posedge clk); #1; c++; end
    per = c - s;
  endtask
  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  // reset state: crystal selected, divide chain from crystal
  task automatic t_reset();
    rd(A_CTRL);
    `CHK(rdv, 32'h0000_002f)
    rd(A_VRS);
    `CHK(rdv, 32'h0000_0040)
    `CHK(fbm, 12'h001)
    `CHK(pon, 1'b1)
    meas(0);
    `CHK(per, 2 * XP)
    meas(1);
    `CHK(per, 4 * XP)
    $display("test reset done");
  endtask
  // on/select interlocks and exponent fields
  task automatic t_ctrl();
    wr(A_VRS, 8'h0b);
    wr(A_CTRL, 8'h0f);
    rd(A_CTRL);
    `CHK(rdv, 32'h0000_000f)
    `CHK(pon, 1'b0)
    wr(A_CTRL, 8'h16);
    rd(A_CTRL);
    `CHK(rdv, 32'h0000_0006)
    wr(A_CTRL, 8'h36);
    rd(A_CTRL);
    `CHK(rdv, 32'h0000_0026)
    wr(A_CTRL, 8'h16);
    rd(A_CTRL);
    `CHK(rdv, 32'h0000_0036)
    wr(A_CTRL, 8'h16);
    rd(A_CTRL);
    `CHK(rdv, 32'h0000_0036)
    `CHK({pre, rexp}, 4'h6)
    rd(A_CTR);
    `CHK(rdv, 32'h0000_002c)
    $display("test ctrl done");
  endtask
  // vco as source, feedback and reference dividers
  task automatic t_vco();
    repeat (80) @(posedge clk);
    meas(0);
    `CHK(per, 2 * VP)
    meas(1);
    `CHK(per, 4 * VP)
    wr(A_MULH, 8'h00);
    wr(A_MULL, 8'h03);
    wr(A_RDS, 8'h05);
    meas(3);
    `CHK(per, 3 * 2 * VP)
    meas(2);
    `CHK(per, 5 * XP)
    `CHK(rdiv, 4'h5)
    wr(A_MULL, 8'h00);
    wr(A_RDS, 8'h00);
    `CHK({fbm, rdiv}, 16'h0011)
    wr(A_MULH, 8'h0a);
    wr(A_MULL, 8'h5c);
    `CHK(fbm, 12'ha5c)
    $display("test vco done");
  endtask
  // zero linear factor forces the crystal back
  task automatic t_zero_l();
    wr(A_VRS, 8'h00);
    rd(A_CTRL);
    `CHK(rdv, 32'h0000_0026)
    `CHK({pon, lin}, 9'h000)
    repeat (80) @(posedge clk);
    meas(0);
    `CHK(per, 2 * XP)
    $display("test zero_l done");
  endtask
  // unmapped place answered with error, read as zero
  task automatic t_err();
    rd(10'h3fc);
    `CHK({resp, rdv}, {RESP_SLVERR, 32'h0})
    wr(10'h3fc, 8'hff);
    `CHK(resp, RESP_SLVERR)
    strb <= 4'h0;
    wr(A_MULL, 8'h77);
    strb <= 4'h1;
    `CHK({resp, fbm}, {RESP_OKAY, 12'ha5c})
    $display("test err done");
  endtask
  // crystal output gated by enable, buffered copy always follows the pin
  task automatic t_osc();
    wr(A_VRS, 8'h0b);
    `CHK(pon, 1'b1)
    repeat (30) begin @(posedge clk); #1; `CHK({xc, bxc}, {osc, osc}) end
    en_req <= 1'b0;
    repeat (30) begin @(posedge clk); #1; `CHK({xc, bxc}, {1'b0, osc}) end
    `CHK(pon, 1'b0)
    en_req <= 1'b1;
    $display("test osc done");
  endtask
  // --------------------------------------------------------------------------
  // sequence, watchdog and verdict
  // --------------------------------------------------------------------------
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
    begin
      $display("SIMULATION PASSED");
    end
    else
    begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // stimulus keeps divider settings within safe frequencies
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_ctrl();
    t_vco();
    t_zero_l();
    t_err();
    t_osc();
    test_done();
  end
  // cut a hang short
  initial
  begin
    #1_500_000;
    n_fail++;
    test_done();
  end
endmodule // test_cgs_top
